// ### cgr_dac_gain_map.v
// Purpose: turn the DAC gain code into attenuation and mute
// Assumes: code is a stable register value
// Notes: outputs are registered, one cycle behind the code
`timescale 1ns/1ps
`include "cgr_defs.vh"

module cgr_dac_gain_map (
    input wire ref_clk, // clock
    input wire rst_b, // async reset, active low
    input wire [5:0] gainCode, // dac gain code
    output reg [6:0] attHalfDb, // attenuation in 0.5 dB units
    output reg muted // stage silenced
);

// ----------------------------------------
// decode
// ----------------------------------------
function [6:0] dacAtt;
    input [5:0] code;
    reg [7:0] prod;
    begin
        prod = {2'h0, code} * {1'b0, `CGR_DAC_STEP_HDB};
        if (code <= `CGR_DAC_LINEAR_MAX) begin
            dacAtt = prod[6:0];
        end else if (code == `CGR_DAC_CODE_42) begin
            dacAtt = `CGR_DAC_ATT_42;
        end else if (code == `CGR_DAC_CODE_48) begin
            dacAtt = `CGR_DAC_ATT_48;
        end else if (code == `CGR_DAC_CODE_54) begin
            dacAtt = `CGR_DAC_ATT_54;
        end else begin
            dacAtt = 7'h00; // mute and unused codes carry no finite figure
        end
    end
endfunction

always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
        attHalfDb <= 7'h00;
        muted <= 1'b0;
    end else begin
        attHalfDb <= dacAtt(gainCode);
        // codes above mute are unused; treated as mute so no stray gain escapes
        muted <= (gainCode >= `CGR_DAC_CODE_MUTE);
    end
end

endmodule // cgr_dac_gain_map

// ### cgr_defs.vh
// Purpose: constants for the codec gain and routing register bank
// Assumes: included by bare name from each design file
// Notes: definitions only
`ifndef CGR_DEFS_VH
`define CGR_DEFS_VH

// ----------------------------------------
// host port layout
// ----------------------------------------
`define CGR_ADDR_W 5
`define CGR_NUM_MSB 2
`define CGR_SUB_MSB 4
`define CGR_SUB_LSB 3
`define CGR_REG_GAIN 3'h5
`define CGR_REG_ROUTE 3'h6

// ----------------------------------------
// selector codes in data bits 7:6 of register 5
// ----------------------------------------
`define CGR_SEL_MSB 7
`define CGR_SEL_LSB 6
`define CGR_SEL_ADC 2'h0
`define CGR_SEL_DAC 2'h1
`define CGR_SEL_SIDE 2'h2
`define CGR_SEL_SPK 2'h3

// ----------------------------------------
// register 6 selector bit and reserved bit
// ----------------------------------------
`define CGR_XP_SEL_BIT 7
`define CGR_XP_RSVD_BIT 6

// ----------------------------------------
// field positions
// ----------------------------------------
`define CGR_GAIN6_MSB 5
`define CGR_AST_GAIN_MSB 5
`define CGR_AST_GAIN_LSB 3
`define CGR_DST_GAIN_MSB 2
`define CGR_SPK_GAIN_MSB 5
`define CGR_SPK_GAIN_LSB 4
`define CGR_SPK_RSVD_MSB 3
`define CGR_IN_HDS_LOOP 6
`define CGR_IN_HNS_LOOP 5
`define CGR_IN_CID 4
`define CGR_IN_LINE 3
`define CGR_IN_MIC 2
`define CGR_IN_HNS 1
`define CGR_IN_HDS 0
`define CGR_OUT_ST_HDS 5
`define CGR_OUT_ST_HNS 4
`define CGR_OUT_SPK 3
`define CGR_OUT_LINE 2
`define CGR_OUT_HNS 1
`define CGR_OUT_HDS 0

// ----------------------------------------
// reset values
// ----------------------------------------
`define CGR_RST_GAIN6 6'h00
`define CGR_RST_ST3 3'h0
`define CGR_RST_SPK_GAIN 2'h0
`define CGR_RST_SPK_RSVD 4'h0
`define CGR_RST_XP_IN 7'h00
`define CGR_RST_XP_OUT 6'h00

// ----------------------------------------
// gain maps, DAC attenuation in half-dB units, sidetone in dB
// ----------------------------------------
`define CGR_DAC_LINEAR_MAX 6'h1b
`define CGR_DAC_CODE_42 6'h1c
`define CGR_DAC_CODE_48 6'h1d
`define CGR_DAC_CODE_54 6'h1e
`define CGR_DAC_CODE_MUTE 6'h1f
`define CGR_DAC_STEP_HDB 7'h03
`define CGR_DAC_ATT_42 7'h54
`define CGR_DAC_ATT_48 7'h60
`define CGR_DAC_ATT_54 7'h6c
`define CGR_ST_CODE_MUTE 3'h7
`define CGR_ST_BASE_DB 5'h09
`define CGR_ST_STEP_DB 5'h03

`endif

// ### cgr_regs.v
// Purpose: host-programmed gain and crosspoint register bank of the codec
// Assumes: host port strobes are one cycle long and synchronous to ref_clk
// Notes: register 5 and 6 hold several sub-registers told apart by data bits
`timescale 1ns/1ps
`include "cgr_defs.vh"

// Contract
// - register 5 write with top bits 01 loads DAC gain; 1.5 dB steps to -40.5.
// - DAC codes 28, 29, 30 give -42, -48 and -54 dB.
// - DAC gain code 31 mutes the DAC gain stage.
// - top bits 10 load analog sidetone gain bits 5:3, -9 dB down 3 dB steps.
// - analog sidetone code 7 mutes and disconnects the analog sidetone.
// - same write loads digital sidetone bits 2:0, -9 to -27 dB, 7 mutes.
// - speaker sub-register bits 3:0 reserved, reset 0000.
// - register 6 with bit 7 clear writes the seven input routing selects.
// - bit 6 loops headset input to headset output, reset 0.
// - bit 5 loops handset input to handset output, reset 0.
// - bit 4 routes caller-ID input to the ADC, reset 0.
// - bit 3 routes line input to the ADC, reset 0.
// - bit 2 routes microphone input to the ADC, reset 0.
// - bit 1 routes handset input to the ADC, reset 0.
// - bit 0 routes headset input to the ADC, reset 0.
// - register 6 with bit 7 set writes output selects; bit 6 read-only.
// - top bits 00 load the ADC gain code, touching no other sub-register.
// - output bits 5 and 4 send analog sidetone to headset, handset outputs.
// - output bits 3 to 0 send DAC to speaker, line, handset, headset.
module cgr_regs (
    input wire ref_clk, // 25 MHz clock
    input wire rst_b, // async reset, active low
    input wire [`CGR_ADDR_W-1:0] hostAddr, // 2:0 register number, 4:3 read sub-select
    input wire [7:0] hostWrData, // write data with selector bits
    input wire hostWrStb, // write strobe, one cycle
    input wire hostRdStb, // read strobe, one cycle
    output reg [7:0] hostRdData, // read data, valid the cycle after the strobe
    output reg hostRdErr, // read strobed in the previous cycle hit no register
    output reg [5:0] adcGainCode, // adc gain code
    output reg [5:0] dacGainCode, // dac gain code
    output reg [2:0] analogSidetoneGain, // analog sidetone gain code
    output reg [2:0] digitalSidetoneGain, // digital sidetone gain code
    output reg [1:0] speakerGain, // speaker gain, dB
    output reg headsetLoopThrough, // headset in to headset out
    output reg handsetLoopThrough, // handset in to handset out
    output reg callerIdToAdc, // caller-ID input to adc
    output reg lineInToAdc, // line input to adc
    output reg microphoneToAdc, // microphone input to adc
    output reg handsetInToAdc, // handset input to adc
    output reg headsetInToAdc, // headset input to adc
    output reg sidetoneToHeadsetOut, // analog sidetone to headset out
    output reg sidetoneToHandsetOut, // analog sidetone to handset out
    output reg dacToLoudspeaker, // dac to speaker driver
    output reg dacToLineDriver, // dac to line driver
    output reg dacToHandsetDriver, // dac to handset driver
    output reg dacToHeadsetDriver, // dac to headset driver
    output wire [6:0] dacAttHalfDb, // dac attenuation, 0.5 dB units
    output wire dacMuted, // dac gain stage silenced
    output wire [4:0] analogSidetoneAttDb, // analog sidetone attenuation, dB
    output wire analogSidetoneMuted, // analog sidetone disconnected
    output wire [4:0] digitalSidetoneAttDb, // digital sidetone attenuation, dB
    output wire digitalSidetoneMuted // digital sidetone silenced
);

// ----------------------------------------
// decode helpers
// ----------------------------------------
function [1:0] subSel;
    input [7:0] data;
    begin
        subSel = data[`CGR_SEL_MSB:`CGR_SEL_LSB];
    end
endfunction

function isReg;
    input [`CGR_NUM_MSB:0] num;
    input [`CGR_NUM_MSB:0] want;
    begin
        isReg = (num == want);
    end
endfunction

// ----------------------------------------
// write decode
// ----------------------------------------
wire [`CGR_NUM_MSB:0] regNum;
wire [1:0] rdSub;
wire wrGain;
wire wrRoute;
wire wrAdc;
wire wrDac;
wire wrSide;
wire wrSpk;
wire wrXpIn;
wire wrXpOut;

assign regNum = hostAddr[`CGR_NUM_MSB:0];
assign rdSub = hostAddr[`CGR_SUB_MSB:`CGR_SUB_LSB];
assign wrGain = hostWrStb && isReg(regNum, `CGR_REG_GAIN);
assign wrRoute = hostWrStb && isReg(regNum, `CGR_REG_ROUTE);
// each strobe to register 5 or 6 reaches exactly one sub-register; the others hold
assign wrAdc = wrGain && (subSel(hostWrData) == `CGR_SEL_ADC);
assign wrDac = wrGain && (subSel(hostWrData) == `CGR_SEL_DAC);
assign wrSide = wrGain && (subSel(hostWrData) == `CGR_SEL_SIDE);
assign wrSpk = wrGain && (subSel(hostWrData) == `CGR_SEL_SPK);
assign wrXpIn = wrRoute && !hostWrData[`CGR_XP_SEL_BIT];
assign wrXpOut = wrRoute && hostWrData[`CGR_XP_SEL_BIT];

// ----------------------------------------
// register 5 sub-registers
// ----------------------------------------
reg [3:0] spkReservedQ;

always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
        adcGainCode <= `CGR_RST_GAIN6;
    end else if (wrAdc) begin
        adcGainCode <= hostWrData[`CGR_GAIN6_MSB:0];
    end
end

always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
        dacGainCode <= `CGR_RST_GAIN6;
    end else if (wrDac) begin
        dacGainCode <= hostWrData[`CGR_GAIN6_MSB:0];
    end
end

always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
        analogSidetoneGain <= `CGR_RST_ST3;
        digitalSidetoneGain <= `CGR_RST_ST3;
    end else if (wrSide) begin
        analogSidetoneGain <= hostWrData[`CGR_AST_GAIN_MSB:`CGR_AST_GAIN_LSB];
        digitalSidetoneGain <= hostWrData[`CGR_DST_GAIN_MSB:0];
    end
end

always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
        speakerGain <= `CGR_RST_SPK_GAIN;
        spkReservedQ <= `CGR_RST_SPK_RSVD;
    end else if (wrSpk) begin
        speakerGain <= hostWrData[`CGR_SPK_GAIN_MSB:`CGR_SPK_GAIN_LSB];
        // reserved bits kept as written so software reads back what it wrote
        spkReservedQ <= hostWrData[`CGR_SPK_RSVD_MSB:0];
    end
end

// ----------------------------------------
// register 6 input crosspoint
// ----------------------------------------
always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
        headsetLoopThrough <= 1'b0;
        handsetLoopThrough <= 1'b0;
        callerIdToAdc <= 1'b0;
        lineInToAdc <= 1'b0;
        microphoneToAdc <= 1'b0;
        handsetInToAdc <= 1'b0;
        headsetInToAdc <= 1'b0;
    end else if (wrXpIn) begin
        headsetLoopThrough <= hostWrData[`CGR_IN_HDS_LOOP];
        handsetLoopThrough <= hostWrData[`CGR_IN_HNS_LOOP];
        callerIdToAdc <= hostWrData[`CGR_IN_CID];
        lineInToAdc <= hostWrData[`CGR_IN_LINE];
        microphoneToAdc <= hostWrData[`CGR_IN_MIC];
        handsetInToAdc <= hostWrData[`CGR_IN_HNS];
        headsetInToAdc <= hostWrData[`CGR_IN_HDS];
    end
end

// ----------------------------------------
// register 6 output crosspoint
// ----------------------------------------
always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
        sidetoneToHeadsetOut <= 1'b0;
        sidetoneToHandsetOut <= 1'b0;
        dacToLoudspeaker <= 1'b0;
        dacToLineDriver <= 1'b0;
        dacToHandsetDriver <= 1'b0;
        dacToHeadsetDriver <= 1'b0;
    end else if (wrXpOut) begin
        // bit 6 is read-only and simply not stored
        sidetoneToHeadsetOut <= hostWrData[`CGR_OUT_ST_HDS];
        sidetoneToHandsetOut <= hostWrData[`CGR_OUT_ST_HNS];
        dacToLoudspeaker <= hostWrData[`CGR_OUT_SPK];
        dacToLineDriver <= hostWrData[`CGR_OUT_LINE];
        dacToHandsetDriver <= hostWrData[`CGR_OUT_HNS];
        dacToHeadsetDriver <= hostWrData[`CGR_OUT_HDS];
    end
end

// ----------------------------------------
// read path
// ----------------------------------------
// a shared number cannot tell sub-registers apart by address alone, so the
// read uses address bits 4:3 as selector, bit 3 alone for register 6; data comes back with its selector
reg [7:0] rdMuxD;
reg rdErrD;

always @* begin
    rdMuxD = 8'h00;
    rdErrD = 1'b0;
    if (isReg(regNum, `CGR_REG_GAIN)) begin
        case (rdSub)
            `CGR_SEL_ADC: rdMuxD = {`CGR_SEL_ADC, adcGainCode};
            `CGR_SEL_DAC: rdMuxD = {`CGR_SEL_DAC, dacGainCode};
            `CGR_SEL_SIDE: rdMuxD = {`CGR_SEL_SIDE, analogSidetoneGain, digitalSidetoneGain};
            `CGR_SEL_SPK: rdMuxD = {`CGR_SEL_SPK, speakerGain, spkReservedQ};
            default: rdMuxD = 8'h00;
        endcase
    end else if (isReg(regNum, `CGR_REG_ROUTE)) begin
        if (!rdSub[0]) begin
            rdMuxD = {1'b0, headsetLoopThrough, handsetLoopThrough, callerIdToAdc,
                      lineInToAdc, microphoneToAdc, handsetInToAdc, headsetInToAdc};
        end else begin
            // reserved bit 6 reads as zero
            rdMuxD = {1'b1, 1'b0, sidetoneToHeadsetOut, sidetoneToHandsetOut,
                      dacToLoudspeaker, dacToLineDriver, dacToHandsetDriver,
                      dacToHeadsetDriver};
        end
    end else begin
        rdErrD = 1'b1;
    end
end

// data stands only in the cycle after the strobe, zero otherwise
always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
        hostRdData <= 8'h00;
        hostRdErr <= 1'b0;
    end else if (hostRdStb) begin
        hostRdData <= rdMuxD;
        hostRdErr <= rdErrD;
    end else begin
        hostRdData <= 8'h00;
        hostRdErr <= 1'b0;
    end
end

// ----------------------------------------
// gain maps
// ----------------------------------------
cgr_dac_gain_map uDacMap (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .gainCode(dacGainCode),
    .attHalfDb(dacAttHalfDb),
    .muted(dacMuted)
);

cgr_sidetone_map uAnalogSt (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .gainCode(analogSidetoneGain),
    .attDb(analogSidetoneAttDb),
    .muted(analogSidetoneMuted)
);

cgr_sidetone_map uDigitalSt (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .gainCode(digitalSidetoneGain),
    .attDb(digitalSidetoneAttDb),
    .muted(digitalSidetoneMuted)
);

endmodule // cgr_regs

// ### cgr_regs_assertions.sv
// Purpose: concurrent checks on the codec gain and routing register bank
// Assumes: sees only the ports of cgr_regs
// Notes: mapped outputs lag the stored codes by one cycle
`timescale 1ns/1ps
`include "cgr_defs.vh"

module cgr_regs_assertions (
    input wire ref_clk, // clock
    input wire rst_b, // async reset
    input wire [`CGR_ADDR_W-1:0] hostAddr, // register number
    input wire [7:0] hostWrData, // write data
    input wire hostWrStb, // write strobe
    input wire [5:0] adcGainCode, // stored
    input wire [5:0] dacGainCode, // stored
    input wire [2:0] analogSidetoneGain, // stored
    input wire [2:0] digitalSidetoneGain, // stored
    input wire [1:0] speakerGain, // stored
    input wire headsetLoopThrough, // xp in
    input wire handsetLoopThrough, // xp in
    input wire callerIdToAdc, // xp in
    input wire lineInToAdc, // xp in
    input wire microphoneToAdc, // xp in
    input wire handsetInToAdc, // xp in
    input wire headsetInToAdc, // xp in
    input wire sidetoneToHeadsetOut, // xp out
    input wire sidetoneToHandsetOut, // xp out
    input wire dacToLoudspeaker, // xp out
    input wire dacToLineDriver, // xp out
    input wire dacToHandsetDriver, // xp out
    input wire dacToHeadsetDriver, // xp out
    input wire [6:0] dacAttHalfDb, // mapped
    input wire dacMuted, // mapped
    input wire [4:0] analogSidetoneAttDb, // mapped
    input wire analogSidetoneMuted, // mapped
    input wire [4:0] digitalSidetoneAttDb, // mapped
    input wire digitalSidetoneMuted // mapped
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);
    wire wr5 = hostWrStb && hostAddr[2:0] == 3'h5;
    wire wr6 = hostWrStb && hostAddr[2:0] == 3'h6;
    wire [6:0] xpIn = {headsetLoopThrough, handsetLoopThrough, callerIdToAdc, lineInToAdc,
        microphoneToAdc, handsetInToAdc, headsetInToAdc};
    wire [5:0] xpOut = {sidetoneToHeadsetOut, sidetoneToHandsetOut, dacToLoudspeaker,
        dacToLineDriver, dacToHandsetDriver, dacToHeadsetDriver};

    // ----------------------------------------
    // sub-register loads
    // ----------------------------------------
    adc_load_a: assert property (wr5 && hostWrData[7:6] == 2'h0 |=>
        adcGainCode == $past(hostWrData[5:0]) && $stable(dacGainCode))
        else $error("adc gain load wrong");
    dac_load_a: assert property (wr5 && hostWrData[7:6] == 2'h1 |=>
        dacGainCode == $past(hostWrData[5:0]) && $stable(adcGainCode) && $stable(speakerGain))
        else $error("dac gain load wrong");
    side_load_a: assert property (wr5 && hostWrData[7:6] == 2'h2 |=>
        {analogSidetoneGain, digitalSidetoneGain} == $past(hostWrData[5:0])
        && $stable(dacGainCode)) else $error("sidetone load wrong");
    spk_load_a: assert property (wr5 && hostWrData[7:6] == 2'h3 |=>
        speakerGain == $past(hostWrData[5:4]) && $stable(analogSidetoneGain))
        else $error("speaker load wrong");
    xp_in_a: assert property (wr6 && !hostWrData[7] |=>
        xpIn == $past(hostWrData[6:0]) && $stable(xpOut)) else $error("input xp wrong");
    xp_out_a: assert property (wr6 && hostWrData[7] |=>
        xpOut == $past(hostWrData[5:0]) && $stable(xpIn)) else $error("output xp wrong");

    // ----------------------------------------
    // gain maps
    // ----------------------------------------
    dac_lin_map_a: assert property (dacGainCode <= 6'h1b |=>
        !dacMuted && dacAttHalfDb == 7'h03 * {1'b0, $past(dacGainCode)})
        else $error("dac linear map wrong");
    dac_step_map_a: assert property (dacGainCode inside {[6'h1c:6'h1e]} |=>
        !dacMuted && dacAttHalfDb == 7'h54 + 7'h0c * {5'h00, $past(dacGainCode[1:0])})
        else $error("dac coarse map wrong");
    dac_mute_a: assert property (dacGainCode == 6'h1f |=> dacMuted)
        else $error("dac mute missing");
    ast_map_a: assert property (1'b1 |=>
        analogSidetoneMuted == ($past(analogSidetoneGain) == 3'h7) && (analogSidetoneMuted
        || analogSidetoneAttDb == 5'h09 + 5'h03 * {2'h0, $past(analogSidetoneGain)}))
        else $error("analog sidetone map wrong");
    dst_map_a: assert property (1'b1 |=>
        digitalSidetoneMuted == ($past(digitalSidetoneGain) == 3'h7) && (digitalSidetoneMuted
        || digitalSidetoneAttDb == 5'h09 + 5'h03 * {2'h0, $past(digitalSidetoneGain)}))
        else $error("digital sidetone map wrong");
endmodule // cgr_regs_assertions

bind cgr_regs cgr_regs_assertions cgr_regs_assertions_inst (.*);

// ### cgr_sidetone_map.v
// Purpose: turn a 3-bit sidetone gain code into attenuation and mute
// Assumes: code is a stable register value
// Notes: used for both analog and digital sidetone; registered outputs
`timescale 1ns/1ps
`include "cgr_defs.vh"

module cgr_sidetone_map (
    input wire ref_clk, // clock
    input wire rst_b, // async reset, active low
    input wire [2:0] gainCode, // sidetone gain code
    output reg [4:0] attDb, // attenuation in dB
    output reg muted // sidetone disconnected
);

wire [4:0] stepDb;

// code 0 is 9 dB, each step adds 3 dB, code 6 reaches 27 dB
assign stepDb = {2'h0, gainCode} * `CGR_ST_STEP_DB;

always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
        attDb <= `CGR_ST_BASE_DB;
        muted <= 1'b0;
    end else begin
        muted <= (gainCode == `CGR_ST_CODE_MUTE);
        if (gainCode == `CGR_ST_CODE_MUTE) begin
            attDb <= 5'h00;
        end else begin
            attDb <= `CGR_ST_BASE_DB + stepDb;
        end
    end
end

endmodule // cgr_sidetone_map

// ### tb.sv
// Purpose: self-checking bench for cgr_regs
// Assumes: host port driven right after the rising edge
// Notes: a reference model of the sub-registers predicts every output
`timescale 1ns/1ps
`include "cgr_defs.vh"

module tb;
    reg ref_clk = 1'b0;
    reg rst_b = 1'b0;
    reg [4:0] hostAddr = 5'h00;
    reg [7:0] hostWrData = 8'h00;
    reg hostWrStb = 1'b0;
    reg hostRdStb = 1'b0;
    wire [7:0] hostRdData;
    wire hostRdErr;
    wire [5:0] adcGainCode, dacGainCode;
    wire [2:0] analogSidetoneGain, digitalSidetoneGain;
    wire [1:0] speakerGain;
    wire headsetLoopThrough, handsetLoopThrough, callerIdToAdc, lineInToAdc;
    wire microphoneToAdc, handsetInToAdc, headsetInToAdc;
    wire sidetoneToHeadsetOut, sidetoneToHandsetOut, dacToLoudspeaker;
    wire dacToLineDriver, dacToHandsetDriver, dacToHeadsetDriver;
    wire [6:0] dacAttHalfDb;
    wire [4:0] analogSidetoneAttDb, digitalSidetoneAttDb;
    wire dacMuted, analogSidetoneMuted, digitalSidetoneMuted;
    integer fails = 0;
    integer tests_run = 0;
    integer seed = 72996;
    integer i;
    reg [4:0] ra;
    reg [7:0] rv;
    reg pick;
    reg [5:0] mAdc, mDac, mSide, mSpk, mOut;
    reg [6:0] mIn;

    cgr_regs cgr_regs_inst (.*);

    always #20 ref_clk = ~ref_clk;

    // ----------------------------------------
    // model and checks
    // ----------------------------------------
    // mute flag in bit 7, attenuation zero while muted
    function [7:0] dacMap(input integer c);
        if (c < 28) dacMap = c * 3;
        else if (c < 31) dacMap = 84 + (c - 28) * 12;
        else dacMap = 8'h80;
    endfunction
    function [5:0] stMap(input integer c);
        stMap = (c == 7) ? 6'h20 : 9 + 3 * c;
    endfunction
    task chk(input [8:0] seen, input [8:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task end_sim;
        if (fails == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task wr(input [4:0] a, input [7:0] d);
        @(posedge ref_clk);
        hostAddr <= a;
        hostWrData <= d;
        hostWrStb <= 1'b1;
        @(posedge ref_clk);
        hostWrStb <= 1'b0;
        if (a[2:0] == 3'h5) begin
            case (d[7:6])
                2'h0: mAdc = d[5:0];
                2'h1: mDac = d[5:0];
                2'h2: mSide = d[5:0];
                default: mSpk = d[5:0];
            endcase
        end
        if (a[2:0] == 3'h6) begin
            if (d[7]) mOut = d[5:0];
            else mIn = d[6:0];
        end
    endtask
    // read data carries the sub-select in its top bits
    task rd(input [4:0] a);
        reg [8:0] e;
        e = 9'h100;
        if (a[2:0] == 3'h5) e = {1'b0, a[4:3], a[4:3] == 2'h0 ? mAdc :
            a[4:3] == 2'h1 ? mDac : a[4:3] == 2'h2 ? mSide : mSpk};
        if (a[2:0] == 3'h6) e = a[3] ? {3'h2, mOut} : {2'h0, mIn};
        @(posedge ref_clk);
        hostAddr <= a;
        hostRdStb <= 1'b1;
        @(posedge ref_clk);
        hostRdStb <= 1'b0;
        @(negedge ref_clk);
        chk({hostRdErr, hostRdData}, e);
    endtask
    // waits one extra edge so the mapped outputs have settled
    task chkAll;
        @(posedge ref_clk);
        @(negedge ref_clk);
        chk(adcGainCode, mAdc);
        chk(dacGainCode, mDac);
        chk({analogSidetoneGain, digitalSidetoneGain}, mSide);
        chk(speakerGain, mSpk[5:4]);
        chk({headsetLoopThrough, handsetLoopThrough, callerIdToAdc, lineInToAdc,
            microphoneToAdc, handsetInToAdc, headsetInToAdc}, mIn);
        chk({sidetoneToHeadsetOut, sidetoneToHandsetOut, dacToLoudspeaker, dacToLineDriver,
            dacToHandsetDriver, dacToHeadsetDriver}, mOut);
        chk({dacMuted, dacAttHalfDb}, dacMap(mDac));
        chk({analogSidetoneMuted, analogSidetoneAttDb}, stMap(mSide[5:3]));
        chk({digitalSidetoneMuted, digitalSidetoneAttDb}, stMap(mSide[2:0]));
    endtask

    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        {mAdc, mDac, mSide, mSpk, mOut, mIn} = 37'h0;
        repeat (5) @(posedge ref_clk);
        rst_b <= 1'b1;
        chkAll;
        rd(5'h1d);
        rd(5'h07);
        for (i = 0; i < 64; i = i + 1) begin
            wr(5'h05, {2'h1, i[5:0]});
            chkAll;
            wr(5'h05, {2'h2, i[5:0]});
            chkAll;
        end
        wr(5'h06, 8'hff);
        rd(5'h0e);
        wr(5'h06, 8'h7f);
        rd(5'h06);
        // write strobe then read strobe on the very next edge, no idle cycle
        @(posedge ref_clk);
        hostAddr <= 5'h05;
        hostWrData <= 8'h5e;
        hostWrStb <= 1'b1;
        @(posedge ref_clk);
        hostWrStb <= 1'b0;
        hostAddr <= 5'h0d;
        hostRdStb <= 1'b1;
        @(posedge ref_clk);
        hostRdStb <= 1'b0;
        mDac = 6'h1e;
        @(negedge ref_clk);
        chk({hostRdErr, hostRdData}, 9'h05e);
        chkAll;
        for (i = 0; i < 400; i = i + 1) begin
            ra = $random(seed);
            rv = $random(seed);
            // separate draw, so written data keeps bit 0 free to be 0 or 1
            pick = $random(seed);
            // steer most traffic onto the two mapped numbers
            if (!ra[2]) ra[2:0] = ra[0] ? 3'h5 : 3'h6;
            if (pick) begin
                wr(ra, rv);
                chkAll;
            end else begin
                rd(ra);
            end
        end
        @(posedge ref_clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'b1;
        {mAdc, mDac, mSide, mSpk, mOut, mIn} = 37'h0;
        chkAll;
        rd(5'h1d);
        end_sim;
    end

    initial begin
        #(40 * 10000);
        fails = fails + 1;
        end_sim;
    end
endmodule // tb
